// ### src/jsr_unit.sv
// Function
// - one-bit bypass path, no register address
// - bypass command routes serial in via bypass
// - bypass bit loads capture value in Capture-DR
// - 16-bit instruction register, read-only to software
// - instruction resets to identification command
// - test reset or Test-Logic-Reset reinitialises instruction
// - instruction shifts accepted in any processor mode
// - field at bits 15..8, reset EF hex
// - bits 7..2 read as one
// - bit 1 reads as zero
// - bit 0 reads as one
// - decode top four instruction bits into commands, top three for the interrupt request
// - 385-cell pin scan chain
// - scan chain reachable only serially
// - extest, sample, clamp, high-z boundary commands
// - cell 384 next to serial input
// - test reset synchronised to the system clock, active low
// - output timing depends on held command
module jsr_unit
	import jsr_pkg::*;
#(
	parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001, // arbitrary value
	parameter int unsigned     LEN      = BSR_LEN
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_b_i,
	input  wire logic              ce_i,
	input  wire logic              tck_i,
	input  wire logic              tms_i,
	input  wire logic              tdi_i,
	input  wire logic              trst_b_i,
	output logic                   tdo_o,
	output logic                   tdo_oe_o,
	input  wire logic [LEN-1:0]    pin_cap_i,
	output logic      [LEN-1:0]    bsr_out_o,
	output logic                   bsr_drive_o,
	output logic                   pads_highz_o,
	output logic                   sys_reset_o,
	output logic                   irq_o,
	input  wire logic [REG_AW-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [31:0]       reg_rdata_o
);
	logic [3:0]     pins_s;
	logic           tck_s;
	logic           tms_s;
	logic           tdi_s;
	logic           trst_b_s;
	logic           tck_q;
	logic           tck_rise;
	logic           tck_fall;
	jsr_tap_t       tap;
	jsr_tap_t       next_tap;
	logic [IR_W-1:0] ir_shift;
	logic [IR_W-1:0] instruction_field;
	logic [ID_W-1:0] id_shift;
	logic           bypass_bit;
	jsr_cmd_t       cmd;
	logic           sel_bsr;
	logic           sel_id;
	logic           cap_dr;
	logic           sh_dr;
	logic           upd_dr;
	logic           cap_ir;
	logic           sh_ir;
	logic           upd_ir;
	logic           dr_so;
	logic           irq_pend;
	logic           irq_en;
	logic           irq_set;
	logic [SIR_W-1:0] scan_instruction;
	logic [LEN-1:0] pin_cap_s;

	jsr_scan_if sif ();

	// link pins come from the tester's clock world
	jsr_sync #(
		.W       (4),
		.RST_VAL (4'h0)
	) u_sync_pins (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.d_i       ({tck_i, tms_i, tdi_i, trst_b_i}),
		.q_o       (pins_s)
	);

	jsr_sync #(
		.W       (LEN),
		.RST_VAL ('0)
	) u_sync_cap (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.d_i       (pin_cap_i),
		.q_o       (pin_cap_s)
	);

	assign tck_s    = pins_s[3];
	assign tms_s    = pins_s[2];
	assign tdi_s    = pins_s[1];
	assign trst_b_s = pins_s[0];

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tck_q <= 1'b0;
		end else if (ce_i) begin
			tck_q <= tck_s;
		end
	end

	assign tck_rise = tck_s & ~tck_q;
	assign tck_fall = ~tck_s & tck_q;

	// tap sequencer
	always_comb begin
		next_tap = tap;
		unique case (tap)
			TAP_TLR:    next_tap = tms_s ? TAP_TLR    : TAP_RTI;
			TAP_RTI:    next_tap = tms_s ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: next_tap = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: next_tap = tms_s ? TAP_TLR    : TAP_CAP_IR;
			TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: next_tap = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_RTI;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tap <= TAP_TLR;
		end else if (ce_i) begin
			if (!trst_b_s) begin
				tap <= TAP_TLR;
			end else if (tck_rise) begin
				tap <= next_tap;
			end
		end
	end

	// capture and shift act on rising test clock, updates on falling
	assign cap_dr = tck_rise && (tap == TAP_CAP_DR);
	assign sh_dr  = tck_rise && (tap == TAP_SH_DR);
	assign upd_dr = tck_fall && (tap == TAP_UPD_DR);
	assign cap_ir = tck_rise && (tap == TAP_CAP_IR);
	assign sh_ir  = tck_rise && (tap == TAP_SH_IR);
	assign upd_ir = tck_fall && (tap == TAP_UPD_IR) && trst_b_s;

	// instruction path, never blocked by processor state
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ir_shift <= IR_CAPTURE;
		end else if (ce_i) begin
			if (cap_ir) begin
				ir_shift <= IR_CAPTURE;
			end else if (sh_ir) begin
				ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			instruction_field <= IR_RESET;
		end else if (ce_i) begin
			if (!trst_b_s || tap == TAP_TLR) begin
				instruction_field <= IR_RESET;
			end else if (upd_ir) begin
				instruction_field <= ir_shift;
			end
		end
	end

	// reserved codes fall back to bypass; the tester must not send them
	always_comb begin
		cmd = CMD_RESERVED;
		if (instruction_field[7:5] == OP_IRQ) begin
			cmd = CMD_IRQ;
		end else begin
			unique case (instruction_field[7:4])
				OP_EXTEST:  cmd = CMD_EXTEST;
				OP_CLAMP:   cmd = CMD_CLAMP;
				OP_HIGHZ:   cmd = CMD_HIGHZ;
				OP_SAMPLE:  cmd = CMD_SAMPLE;
				OP_RST_NEG: cmd = CMD_RST_NEG;
				OP_RST_ASR: cmd = CMD_RST_ASR;
				OP_IDCODE:  cmd = CMD_IDCODE;
				OP_BYPASS:  cmd = CMD_BYPASS;
				default:    cmd = CMD_RESERVED;
			endcase
		end
	end

	assign sel_bsr = (cmd == CMD_EXTEST) || (cmd == CMD_SAMPLE);
	assign sel_id  = (cmd == CMD_IDCODE);

	// bypass bit: no address, only the serial path sees it
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bypass_bit <= BYP_CAPTURE;
		end else if (ce_i && !sel_bsr && !sel_id) begin
			if (cap_dr) begin
				bypass_bit <= BYP_CAPTURE;
			end else if (sh_dr) begin
				bypass_bit <= tdi_s;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_shift <= ID_VALUE;
		end else if (ce_i && sel_id) begin
			if (cap_dr) begin
				id_shift <= ID_VALUE;
			end else if (sh_dr) begin
				id_shift <= {tdi_s, id_shift[ID_W-1:1]};
			end
		end
	end

	// boundary chain sits behind the serial port only
	assign sif.capture = cap_dr && sel_bsr;
	assign sif.shift   = sh_dr && sel_bsr;
	assign sif.update  = upd_dr && sel_bsr;
	assign sif.si      = tdi_s;

	jsr_bscan #(
		.LEN (LEN)
	) u_chain (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.pin_cap_i (pin_cap_s),
		.sif       (sif),
		.bsr_out_o (bsr_out_o)
	);

	always_comb begin
		if (sel_bsr) begin
			dr_so = sif.so;
		end else if (sel_id) begin
			dr_so = id_shift[0];
		end else begin
			dr_so = bypass_bit;
		end
	end

	// bypass shows its bit at the shifting edge; other paths wait for the falling edge
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (!trst_b_s) begin
				tdo_oe_o <= 1'b0;
			end else if (sh_dr && cmd == CMD_BYPASS) begin
				tdo_o <= tdi_s;
			end else if (tck_fall) begin
				tdo_o    <= (tap == TAP_SH_IR) ? ir_shift[0] : dr_so;
				tdo_oe_o <= (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
			end
		end
	end

	// pad control follows the held command
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bsr_drive_o  <= 1'b0;
			pads_highz_o <= 1'b0;
		end else if (ce_i) begin
			bsr_drive_o  <= (cmd == CMD_EXTEST) || (cmd == CMD_CLAMP);
			pads_highz_o <= (cmd == CMD_HIGHZ);
		end
	end

	// internal reset stays until a negate is updated, even across tap reset
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sys_reset_o <= 1'b0;
		end else if (ce_i && upd_ir) begin
			if (ir_shift[7:4] == OP_RST_ASR) begin
				sys_reset_o <= 1'b1;
			end else if (ir_shift[7:4] == OP_RST_NEG) begin
				sys_reset_o <= 1'b0;
			end
		end
	end

	// one request per update; set beats a same-cycle acknowledge
	assign irq_set = upd_ir && (ir_shift[7:5] == OP_IRQ);

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_pend <= 1'b0;
		end else if (ce_i) begin
			if (irq_set) begin
				irq_pend <= 1'b1;
			end else if (reg_wr_i && reg_addr_i == OFS_CONTROL && reg_wdata_i[CTL_IRQ_ACK]) begin
				irq_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_en <= CTL_IRQ_EN_RST;
		end else if (ce_i && reg_wr_i && reg_addr_i == OFS_CONTROL) begin
			irq_en <= reg_wdata_i[CTL_IRQ_EN];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= irq_pend && irq_en;
		end
	end

	// fixed low byte; writes to this offset are dropped
	assign scan_instruction = {instruction_field, SIR_LOW};

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			reg_rdata_o <= 32'h0000_0000;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					OFS_SCAN_INSTR: reg_rdata_o <= {16'h0000, scan_instruction};
					OFS_STATUS: begin
						reg_rdata_o[ST_IRQ]                  <= irq_pend;
						reg_rdata_o[ST_SRST]                 <= sys_reset_o;
						reg_rdata_o[ST_TAP_LSB +: 4]         <= 4'(tap);
						reg_rdata_o[ST_CMD_LSB +: 4]         <= 4'(cmd);
					end
					OFS_CONTROL: reg_rdata_o[CTL_IRQ_EN] <= irq_en;
					default:     reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// ### src/jsr_pkg.sv
package jsr_pkg;

	// serial path widths
	localparam int unsigned IR_W    = 8;
	localparam int unsigned SIR_W   = 16;
	localparam int unsigned BSR_LEN = 385;
	localparam int unsigned ID_W    = 32;

	// instruction field and its fixed low byte
	localparam int unsigned   IR_LSB      = 8;
	localparam logic [7:0]    IR_RESET    = 8'hEF;
	localparam logic [7:0]    IR_CAPTURE  = 8'h01;
	localparam logic [7:0]    SIR_LOW     = 8'hFD;
	localparam logic          BYP_CAPTURE = 1'b0;

	// opcodes in the top four instruction bits; the interrupt opcode uses only the top three
	localparam logic [3:0] OP_EXTEST  = 4'h0;
	localparam logic [3:0] OP_CLAMP   = 4'h2;
	localparam logic [3:0] OP_HIGHZ   = 4'h3;
	localparam logic [3:0] OP_SAMPLE  = 4'h4;
	localparam logic [3:0] OP_RST_NEG = 4'h6;
	localparam logic [3:0] OP_RST_ASR = 4'h7;
	localparam logic [2:0] OP_IRQ     = 3'h5;
	localparam logic [3:0] OP_IDCODE  = 4'hE;
	localparam logic [3:0] OP_BYPASS  = 4'hF;

	// register port
	localparam int unsigned    REG_AW         = 4;
	localparam logic [REG_AW-1:0] OFS_SCAN_INSTR = 4'h0;
	localparam logic [REG_AW-1:0] OFS_STATUS     = 4'h4;
	localparam logic [REG_AW-1:0] OFS_CONTROL    = 4'h8;
	localparam int unsigned    CTL_IRQ_ACK    = 0;
	localparam int unsigned    CTL_IRQ_EN     = 1;
	localparam logic           CTL_IRQ_EN_RST = 1'b1;
	localparam int unsigned    ST_IRQ         = 0;
	localparam int unsigned    ST_SRST        = 1;
	localparam int unsigned    ST_TAP_LSB     = 4;
	localparam int unsigned    ST_CMD_LSB     = 8;

	typedef enum {
		CMD_EXTEST, CMD_CLAMP, CMD_HIGHZ, CMD_SAMPLE, CMD_RST_NEG,
		CMD_RST_ASR, CMD_IRQ, CMD_IDCODE, CMD_BYPASS, CMD_RESERVED
	} jsr_cmd_t;

	typedef enum {
		TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
	} jsr_tap_t;

endpackage

// ### src/jsr_scan_if.sv
interface jsr_scan_if;
	logic capture;
	logic shift;
	logic update;
	logic si;
	logic so;
	modport ctrl  (output capture, output shift, output update, output si, input so);
	modport chain (input capture, input shift, input update, input si, output so);
endinterface

// ### src/jsr_sync.sv
module jsr_sync
	import jsr_pkg::*;
#(
	parameter int unsigned     W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          clk_sys_i,
	input  wire logic          rst_b_i,
	input  wire logic          ce_i,
	input  wire logic [W-1:0]  d_i,
	output logic      [W-1:0]  q_o
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end else if (ce_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// ### src/jsr_bscan.sv
module jsr_bscan
	import jsr_pkg::*;
#(
	parameter int unsigned LEN = BSR_LEN
) (
	input  wire logic            clk_sys_i,
	input  wire logic            rst_b_i,
	input  wire logic            ce_i,
	input  wire logic [LEN-1:0]  pin_cap_i,
	jsr_scan_if.chain            sif,
	output logic      [LEN-1:0]  bsr_out_o
);
	logic [LEN-1:0] pin_scan_chain;

	// cell LEN-1 sits next to the serial input, cell 0 feeds the output
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_scan_chain <= '0;
		end else if (ce_i) begin
			if (sif.capture) begin
				pin_scan_chain <= pin_cap_i;
			end else if (sif.shift) begin
				pin_scan_chain <= {sif.si, pin_scan_chain[LEN-1:1]};
			end
		end
	end

	// update latch keeps pads steady while the chain shifts
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bsr_out_o <= '0;
		end else if (ce_i && sif.update) begin
			bsr_out_o <= pin_scan_chain;
		end
	end

	assign sif.so = pin_scan_chain[0];
endmodule

// ### verif/jsr_tester.sv
module jsr_tester (
	input  logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_b_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock stands still between frames, tdi parked at pull-up level
	initial begin
		tck_o    = 1'b0;
		tms_o    = 1'b1;
		tdi_o    = 1'b1;
		trst_b_o = 1'b0;
	end

	// tdo taken as tck rises, before the device has seen that edge
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#100 q = tdo_i;
		tck_o = 1'b1;
		#100 tck_o = 1'b0;
	endtask

	task automatic tap_reset(input logic pin);
		logic q;
		if (pin) begin
			trst_b_o = 1'b0;
			#200 trst_b_o = 1'b1;
		end else
			repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask

	// from idle through one capture, shift, update; only documented codes are loaded
	task automatic scan(input logic ir, input int n, input logic [384:0] din,
		output logic [384:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule

// ### verif/jsr_unit_properties.sv
module jsr_unit_checker
	import jsr_pkg::*;
#(
	parameter int unsigned LEN = BSR_LEN
) (
	input logic              clk_sys_i,
	input logic              rst_b_i,
	input logic              trst_b_i,
	input logic              tdo_oe_o,
	input logic [LEN-1:0]    bsr_out_o,
	input logic              bsr_drive_o,
	input logic              pads_highz_o,
	input logic              sys_reset_o,
	input logic              irq_o,
	input logic [REG_AW-1:0] reg_addr_i,
	input logic              reg_rd_i,
	input logic [31:0]       reg_rdata_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	chk_ir_fixed_bits: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_SCAN_INSTR
		|-> reg_rdata_o[7:0] == 8'hFD && reg_rdata_o[31:16] == 16'h0)
		else $error("instruction fixed bits wrong");
	chk_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'hC
		|-> reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_drive_excl: assert property (!(bsr_drive_o && pads_highz_o))
		else $error("drive and high-z together");
	chk_sysrst_update: assert property ($changed(sys_reset_o) |-> !tdo_oe_o)
		else $error("system reset moved during shift");
	chk_irq_update: assert property ($rose(irq_o) |-> !tdo_oe_o)
		else $error("interrupt raised during shift");
	chk_bsr_update: assert property (!$stable(bsr_out_o) |-> !tdo_oe_o)
		else $error("chain latch moved during shift");
	chk_trst_reinit: assert property ((!trst_b_i) [*6] |-> !tdo_oe_o)
		else $error("test reset left output enabled");
	chk_reset_clear: assert property ($rose(rst_b_i) |-> !sys_reset_o && !irq_o && !bsr_drive_o)
		else $error("outputs not cleared by reset");
endmodule

bind jsr_unit jsr_unit_checker #(.LEN(LEN)) i_chk (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .trst_b_i(trst_b_i), .tdo_oe_o(tdo_oe_o),
	.bsr_out_o(bsr_out_o), .bsr_drive_o(bsr_drive_o), .pads_highz_o(pads_highz_o),
	.sys_reset_o(sys_reset_o), .irq_o(irq_o), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o));

// ### verif/tb_top.sv
module tb_top
	import jsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned LEN    = BSR_LEN;
	localparam logic [31:0] ID_EXP = 32'h1234_5671; // arbitrary value

	logic              clk_sys_i;
	logic              rst_b_i;
	logic              tck;
	logic              tms;
	logic              tdi;
	logic              trst_b;
	logic              tdo;
	logic              tdo_oe;
	logic              tdo_wire;
	logic [LEN-1:0]    pin_cap;
	logic [LEN-1:0]    bsr_out;
	logic              bsr_drive;
	logic              highz;
	logic              sys_reset;
	logic              irq;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0]       reg_wdata;
	logic [31:0]       reg_rdata;
	logic              reg_wr;
	logic              reg_rd;
	int                fails  = 0;
	int                checks = 0;
	int                cycles = 0;

	// released output floats to the pin pull-up
	assign tdo_wire = tdo_oe ? tdo : 1'b1;

	jsr_unit #(.ID_VALUE(ID_EXP), .LEN(LEN)) i_dut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .trst_b_i(trst_b), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_cap_i(pin_cap),
		.bsr_out_o(bsr_out), .bsr_drive_o(bsr_drive), .pads_highz_o(highz),
		.sys_reset_o(sys_reset), .irq_o(irq), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
	jsr_tester i_tst (.tdo_i(tdo_wire), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_b_o(trst_b));

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk(input logic [384:0] seen, input logic [384:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask

	task automatic load(input logic [3:0] op);
		logic [384:0] q;
		i_tst.scan(1'b1, 8, {377'h0, op, 4'h0}, q);
		chk(q[7:0], IR_CAPTURE);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		rd(OFS_SCAN_INSTR, d);
		chk(d, 32'h0000_EFFD);
		wr(OFS_SCAN_INSTR, 32'h0000_0000);
		rd(OFS_SCAN_INSTR, d);
		chk(d, 32'h0000_EFFD);
		rd(4'hC, d);
		chk(d, 32'h0);
		rd(OFS_STATUS, d);
		chk(d, 32'h0000_0700);
	endtask

	task automatic t_idcode();
		logic [384:0] q;
		i_tst.tap_reset(1'b1);
		i_tst.scan(1'b0, 32, '0, q);
		chk(q[31:0], ID_EXP);
	endtask

	// expected {drive, high-z, system reset, status command}
	task automatic t_cmds();
		logic [31:0] d;
		logic [3:0]  op [8] = '{OP_EXTEST, OP_CLAMP, OP_HIGHZ, OP_SAMPLE, OP_RST_ASR,
			OP_IDCODE, OP_RST_NEG, OP_BYPASS};
		logic [6:0]  ex [8] = '{7'h40, 7'h41, 7'h22, 7'h03, 7'h15, 7'h17, 7'h04, 7'h08};
		for (int i = 0; i < 8; i++) begin
			load(op[i]);
			rd(OFS_SCAN_INSTR, d);
			chk(d, {16'h0, op[i], 4'h0, 8'hFD});
			rd(OFS_STATUS, d);
			chk(d[11:8], ex[i][3:0]);
			chk({bsr_drive, highz, sys_reset}, ex[i][6:4]);
		end
		load({OP_IRQ, 1'b1});
		repeat (2) @(posedge clk_sys_i);
		chk(irq, 1'b1);
		wr(OFS_CONTROL, 32'h0000_0003);
		repeat (2) @(posedge clk_sys_i);
		chk(irq, 1'b0);
		// other interrupt code with the request masked: pending only
		wr(OFS_CONTROL, 32'h0000_0000);
		load({OP_IRQ, 1'b0});
		repeat (2) @(posedge clk_sys_i);
		chk(irq, 1'b0);
		rd(OFS_STATUS, d);
		chk(d[0], 1'b1);
		wr(OFS_CONTROL, 32'h0000_0003);
		repeat (2) @(posedge clk_sys_i);
		chk(irq, 1'b0);
	endtask

	task automatic t_reinit();
		logic [31:0] d;
		load(OP_RST_ASR);
		i_tst.tap_reset(1'b1);
		rd(OFS_SCAN_INSTR, d);
		chk(d, 32'h0000_EFFD);
		chk(sys_reset, 1'b1);
		load(OP_BYPASS);
		i_tst.tap_reset(1'b0);
		rd(OFS_SCAN_INSTR, d);
		chk(d, 32'h0000_EFFD);
		load(OP_RST_NEG);
		chk(sys_reset, 1'b0);
	endtask

	// first bit out is the capture value, then tdi one bit late
	task automatic t_bypass();
		logic [384:0] q;
		load(OP_BYPASS);
		i_tst.scan(1'b0, 8, 385'hB5, q);
		chk(q[7:0], 8'h6A);
	endtask

	task automatic t_chain();
		logic [384:0] q;
		load(OP_SAMPLE);
		i_tst.scan(1'b0, LEN, {55{7'h5A}}, q);
		chk(q, {77{5'h13}});
		chk(bsr_out, {55{7'h5A}});
		load(OP_EXTEST);
		chk(bsr_drive, 1'b1);
	endtask

	initial begin
		rst_b_i   = 1'b0;
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		pin_cap   = {77{5'h13}};
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_idcode();
		t_cmds();
		t_reinit();
		t_bypass();
		t_chain();
		finish_test();
	end
endmodule
